// >>> hw/pbt_engine.sv
`timescale 1ns/1ps
module pbt_engine (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  output logic             req_valid,
  input  wire logic        req_ready,
  output logic      [15:0] req_dst_x,
  output logic      [15:0] req_dst_y,
  output logic      [15:0] req_src_x,
  output logic      [15:0] req_src_y,
  output logic      [15:0] req_pat_x,
  output logic      [15:0] req_pat_y,
  output logic      [15:0] req_msk_x,
  output logic      [15:0] req_msk_y,
  output logic      [3:0]  req_src_map,
  output logic      [3:0]  req_dst_map,
  output logic      [3:0]  req_pat_map,
  output logic      [1:0]  req_msk_mode,
  input  wire logic        rsp_valid,
  input  wire logic [7:0]  rsp_src,
  input  wire logic [7:0]  rsp_dst,
  input  wire logic        rsp_pat,
  input  wire logic        rsp_msk,
  output logic             wr_valid,
  input  wire logic        wr_ready,
  output logic      [15:0] wr_x,
  output logic      [15:0] wr_y,
  output logic      [7:0]  wr_data,
  output logic             busy
);

  logic [7:0]       fg_mix_r, bg_mix_r;
  logic [31:0]      fg_col_r, bg_col_r;
  logic [15:0]      width_r, height_r;
  logic [15:0]      src_x_r, src_y_r, pat_x_r, pat_y_r;
  logic [15:0]      msk_x_r, msk_y_r, dst_x_r, dst_y_r;
  logic [31:0]      pixop_r;
  logic             unsup_r;
  logic             ack_r;
  logic [31:0]      rd_nxt;
  pbt_pkg::pbt_state_t state_r;
  logic [15:0]      xcnt_r, ycnt_r;
  logic             wr_en, start, settle_r;
  logic [1:0]       fgs, bgs, msk_mode;
  logic [3:0]       step, pmap;
  logic [2:0]       oct;
  logic [7:0]       fg_pix, bg_pix, mix_out;
  logic             is_fg, keep;

  // merge bytes under byteenable
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // position along one axis: base plus or minus the step count
  function automatic logic [15:0] walk(input logic [15:0] base,
                                       input logic [15:0] cnt,
                                       input logic        dec);
    return dec ? base - cnt : base + cnt;
  endfunction

  // per-pixel mix; bit code[{~s,~d}] gives every boolean function
  function automatic logic [7:0] mix(input logic [7:0] code,
                                     input logic [7:0] s,
                                     input logic [7:0] d);
    logic [8:0] sum;
    logic [7:0] r;
    sum = {1'b0, s} + {1'b0, d};
    if (code[7:4] == 4'h0) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = code[{~s[i], ~d[i]}];
      end
    end else begin
      case (code)
        pbt_pkg::MIX_MAX:  r = (s > d) ? s : d;
        pbt_pkg::MIX_MIN:  r = (s < d) ? s : d;
        pbt_pkg::MIX_ADDS: r = sum[8] ? 8'hff : sum[7:0];
        pbt_pkg::MIX_DMS:  r = (d > s) ? d - s : 8'h00;
        pbt_pkg::MIX_SMD:  r = (s > d) ? s - d : 8'h00;
        pbt_pkg::MIX_AVG:  r = sum[8:1];
        default:           r = 8'h00;
      endcase
    end
    return r;
  endfunction

  // operation word fields
  assign bgs      = pixop_r[pbt_pkg::BGS_LSB +: 2];
  assign fgs      = pixop_r[pbt_pkg::FGS_LSB +: 2];
  assign step     = pixop_r[pbt_pkg::STEP_LSB +: 4];
  assign pmap     = pixop_r[pbt_pkg::PMAP_LSB +: 4];
  assign msk_mode = pixop_r[pbt_pkg::MASK_LSB +: 2];
  assign oct      = pixop_r[pbt_pkg::OCT_LSB +: 3];

  // avalon slave: one wait cycle, then the access completes
  assign waitrequest = (read | write) & ~ack_r;
  assign wr_en       = write & ack_r;
  assign busy        = (state_r != pbt_pkg::ST_IDLE);
  // parameter writes while busy are dropped so a running job stays coherent
  assign start = wr_en & ~busy & (address == pbt_pkg::PIXOP_IDX);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (read | write) & ~ack_r;
    end
  end

  // read mux; unmapped indices read zero
  always_comb begin
    case (address)
      pbt_pkg::FG_MIX_IDX: rd_nxt = {24'h000000, fg_mix_r};
      pbt_pkg::BG_MIX_IDX: rd_nxt = {24'h000000, bg_mix_r};
      pbt_pkg::FG_COL_IDX: rd_nxt = fg_col_r;
      pbt_pkg::BG_COL_IDX: rd_nxt = bg_col_r;
      pbt_pkg::WIDTH_IDX:  rd_nxt = {16'h0000, width_r};
      pbt_pkg::HEIGHT_IDX: rd_nxt = {16'h0000, height_r};
      pbt_pkg::MSK_X_IDX:  rd_nxt = {16'h0000, msk_x_r};
      pbt_pkg::MSK_Y_IDX:  rd_nxt = {16'h0000, msk_y_r};
      pbt_pkg::SRC_X_IDX:  rd_nxt = {16'h0000, src_x_r};
      pbt_pkg::SRC_Y_IDX:  rd_nxt = {16'h0000, src_y_r};
      pbt_pkg::PAT_X_IDX:  rd_nxt = {16'h0000, pat_x_r};
      pbt_pkg::PAT_Y_IDX:  rd_nxt = {16'h0000, pat_y_r};
      pbt_pkg::DST_X_IDX:  rd_nxt = {16'h0000, dst_x_r};
      pbt_pkg::DST_Y_IDX:  rd_nxt = {16'h0000, dst_y_r};
      pbt_pkg::PIXOP_IDX:  rd_nxt = pixop_r;
      pbt_pkg::STATUS_IDX: rd_nxt = {30'h0, unsup_r, busy};
      default:             rd_nxt = 32'h0000_0000;
    endcase
  end

  // read data latched in the wait cycle, stands in the answer cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      readdata <= 32'h0000_0000;
    end else if (read & ~ack_r) begin
      readdata <= rd_nxt;
    end
  end

  // parameter registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fg_mix_r <= pbt_pkg::MIX_RST;
      bg_mix_r <= pbt_pkg::MIX_RST;
      fg_col_r <= pbt_pkg::COL_RST;
      bg_col_r <= pbt_pkg::COL_RST;
      width_r  <= pbt_pkg::DIM_RST;
      height_r <= pbt_pkg::DIM_RST;
      msk_x_r  <= pbt_pkg::DIM_RST;
      msk_y_r  <= pbt_pkg::DIM_RST;
      src_x_r  <= pbt_pkg::DIM_RST;
      src_y_r  <= pbt_pkg::DIM_RST;
      pat_x_r  <= pbt_pkg::DIM_RST;
      pat_y_r  <= pbt_pkg::DIM_RST;
      dst_x_r  <= pbt_pkg::DIM_RST;
      dst_y_r  <= pbt_pkg::DIM_RST;
      pixop_r  <= pbt_pkg::PIXOP_RST;
    end else if (wr_en & ~busy) begin
      case (address)
        pbt_pkg::FG_MIX_IDX:
          fg_mix_r <= 8'(merge({24'h0, fg_mix_r}, writedata, byteenable));
        pbt_pkg::BG_MIX_IDX:
          bg_mix_r <= 8'(merge({24'h0, bg_mix_r}, writedata, byteenable));
        pbt_pkg::FG_COL_IDX: fg_col_r <= merge(fg_col_r, writedata, byteenable);
        pbt_pkg::BG_COL_IDX: bg_col_r <= merge(bg_col_r, writedata, byteenable);
        pbt_pkg::WIDTH_IDX:
          width_r <= 16'(merge({16'h0, width_r}, writedata, byteenable));
        pbt_pkg::HEIGHT_IDX:
          height_r <= 16'(merge({16'h0, height_r}, writedata, byteenable));
        pbt_pkg::MSK_X_IDX:
          msk_x_r <= 16'(merge({16'h0, msk_x_r}, writedata, byteenable));
        pbt_pkg::MSK_Y_IDX:
          msk_y_r <= 16'(merge({16'h0, msk_y_r}, writedata, byteenable));
        pbt_pkg::SRC_X_IDX:
          src_x_r <= 16'(merge({16'h0, src_x_r}, writedata, byteenable));
        pbt_pkg::SRC_Y_IDX:
          src_y_r <= 16'(merge({16'h0, src_y_r}, writedata, byteenable));
        pbt_pkg::PAT_X_IDX:
          pat_x_r <= 16'(merge({16'h0, pat_x_r}, writedata, byteenable));
        pbt_pkg::PAT_Y_IDX:
          pat_y_r <= 16'(merge({16'h0, pat_y_r}, writedata, byteenable));
        pbt_pkg::DST_X_IDX:
          dst_x_r <= 16'(merge({16'h0, dst_x_r}, writedata, byteenable));
        pbt_pkg::DST_Y_IDX:
          dst_y_r <= 16'(merge({16'h0, dst_y_r}, writedata, byteenable));
        pbt_pkg::PIXOP_IDX: pixop_r <= merge(pixop_r, writedata, byteenable);
        default: ;
      endcase
    end
  end

  // pixel classing and source choice
  always_comb begin
    // colour registers only matter for a colour-sourced side
    fg_pix = (fgs == pbt_pkg::SRC_MAP) ? rsp_src : fg_col_r[7:0];
    bg_pix = (bgs == pbt_pkg::SRC_MAP) ? rsp_src : bg_col_r[7:0];
    case (pmap)
      pbt_pkg::PAT_FG_FIXED: is_fg = 1'b1;
      pbt_pkg::PAT_FROM_SRC: is_fg = (rsp_src != 8'h00);
      default:               is_fg = rsp_pat;
    endcase
    if (step == pbt_pkg::STEP_INV_BLT) begin
      is_fg = ~is_fg; // inverting transfer swaps the classes
    end
    mix_out = is_fg ? mix(fg_mix_r, fg_pix, rsp_dst)
                    : mix(bg_mix_r, bg_pix, rsp_dst);
    // boundary mode: rsp_msk tells whether the pixel is inside the mask
    keep = (msk_mode == pbt_pkg::MASK_OFF) | rsp_msk;
  end

  // engine sequencer
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_r <= pbt_pkg::ST_IDLE;
      xcnt_r  <= 16'h0000;
      ycnt_r  <= 16'h0000;
      unsup_r <= 1'b0;
      settle_r <= 1'b0;
    end else begin
      settle_r <= (state_r == pbt_pkg::ST_FETCH); // coords lag one cycle
      case (state_r)
        pbt_pkg::ST_IDLE: begin
          if (start) begin
            xcnt_r <= 16'h0000;
            ycnt_r <= 16'h0000;
            // line and draw-and-step codes are refused: unsup_r is set and the engine stays idle
            if (writedata[pbt_pkg::STEP_LSB +: 4] == pbt_pkg::STEP_BLT ||
                writedata[pbt_pkg::STEP_LSB +: 4] == pbt_pkg::STEP_INV_BLT ||
                writedata[pbt_pkg::STEP_LSB +: 4] == pbt_pkg::STEP_FILL) begin
              state_r <= pbt_pkg::ST_FETCH;
              unsup_r <= 1'b0;
            end else begin
              unsup_r <= 1'b1;
            end
          end
        end
        pbt_pkg::ST_FETCH: begin
          if (req_ready & settle_r) begin
            state_r <= pbt_pkg::ST_WAIT;
          end
        end
        pbt_pkg::ST_WAIT: begin
          if (rsp_valid) begin
            state_r <= keep ? pbt_pkg::ST_WRITE : pbt_pkg::ST_NEXT;
          end
        end
        pbt_pkg::ST_WRITE: begin
          if (wr_ready) begin
            state_r <= pbt_pkg::ST_NEXT;
          end
        end
        pbt_pkg::ST_NEXT: begin
          // value plus one pixels on each axis
          if (xcnt_r != width_r) begin
            xcnt_r  <= xcnt_r + 16'h0001;
            state_r <= pbt_pkg::ST_FETCH;
          end else if (ycnt_r != height_r) begin
            xcnt_r  <= 16'h0000;
            ycnt_r  <= ycnt_r + 16'h0001;
            state_r <= pbt_pkg::ST_FETCH;
          end else begin
            state_r <= pbt_pkg::ST_IDLE;
          end
        end
        default: state_r <= pbt_pkg::ST_IDLE;
      endcase
    end
  end

  assign req_valid = (state_r == pbt_pkg::ST_FETCH) & settle_r;
  assign wr_valid  = (state_r == pbt_pkg::ST_WRITE);

  // request coordinates; octant bit 2 walks left, bit 1 walks up
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      req_dst_x <= 16'h0000;
      req_dst_y <= 16'h0000;
      req_src_x <= 16'h0000;
      req_src_y <= 16'h0000;
      req_pat_x <= 16'h0000;
      req_pat_y <= 16'h0000;
      req_msk_x <= 16'h0000;
      req_msk_y <= 16'h0000;
    end else begin
      req_dst_x <= walk(dst_x_r, xcnt_r, oct[2]);
      req_dst_y <= walk(dst_y_r, ycnt_r, oct[1]);
      req_src_x <= walk(src_x_r, xcnt_r, oct[2]);
      req_src_y <= walk(src_y_r, ycnt_r, oct[1]);
      req_pat_x <= walk(pat_x_r, xcnt_r, oct[2]);
      req_pat_y <= walk(pat_y_r, ycnt_r, oct[1]);
      // mask map sits at its origin from the destination corner
      req_msk_x <= walk(dst_x_r, xcnt_r, oct[2]) - msk_x_r;
      req_msk_y <= walk(dst_y_r, ycnt_r, oct[1]) - msk_y_r;
    end
  end

  // which maps the pixel reader must touch
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      req_src_map  <= 4'h0;
      req_dst_map  <= 4'h0;
      req_pat_map  <= 4'h0;
      req_msk_mode <= 2'h0;
    end else begin
      // zero map code means the reader skips that map
      req_src_map <= (fgs == pbt_pkg::SRC_MAP || bgs == pbt_pkg::SRC_MAP ||
                      pmap == pbt_pkg::PAT_FROM_SRC)
                     ? pixop_r[pbt_pkg::SMAP_LSB +: 4] : 4'h0;
      req_dst_map <= pixop_r[pbt_pkg::DMAP_LSB +: 4];
      req_pat_map <= (pmap >= pbt_pkg::MAP_A && pmap <= pbt_pkg::MAP_C)
                     ? pmap : 4'h0;
      req_msk_mode <= msk_mode;
    end
  end

  // write-back data captured with the response
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_x    <= 16'h0000;
      wr_y    <= 16'h0000;
      wr_data <= 8'h00;
    end else if (state_r == pbt_pkg::ST_WAIT && rsp_valid) begin
      wr_x    <= req_dst_x;
      wr_y    <= req_dst_y;
      wr_data <= mix_out;
    end
  end

endmodule

// >>> hw/pbt_pkg.sv
package pbt_pkg;

  // register indices; the byte address is four times the index
  localparam logic [7:0] FG_MIX_IDX   = 8'h48;
  localparam logic [7:0] BG_MIX_IDX   = 8'h49;
  localparam logic [7:0] FG_COL_IDX   = 8'h58;
  localparam logic [7:0] BG_COL_IDX   = 8'h5c;
  localparam logic [7:0] WIDTH_IDX    = 8'h60;
  localparam logic [7:0] HEIGHT_IDX   = 8'h62;
  localparam logic [7:0] MSK_X_IDX    = 8'h6c;
  localparam logic [7:0] MSK_Y_IDX    = 8'h6e;
  localparam logic [7:0] SRC_X_IDX    = 8'h70;
  localparam logic [7:0] SRC_Y_IDX    = 8'h72;
  localparam logic [7:0] PAT_X_IDX    = 8'h74;
  localparam logic [7:0] PAT_Y_IDX    = 8'h76;
  localparam logic [7:0] DST_X_IDX    = 8'h78;
  localparam logic [7:0] DST_Y_IDX    = 8'h7a;
  localparam logic [7:0] PIXOP_IDX    = 8'h7c;
  localparam logic [7:0] STATUS_IDX   = 8'h80;

  // reset values
  localparam logic [7:0]  MIX_RST     = 8'h03;
  localparam logic [31:0] COL_RST     = 32'h0000_0000;
  localparam logic [15:0] DIM_RST     = 16'h0000;
  localparam logic [31:0] PIXOP_RST   = 32'h0000_0000;

  // operation word field positions (low bit of each field)
  localparam int BGS_LSB  = 30;
  localparam int FGS_LSB  = 28;
  localparam int STEP_LSB = 24;
  localparam int SMAP_LSB = 20;
  localparam int DMAP_LSB = 16;
  localparam int PMAP_LSB = 12;
  localparam int MASK_LSB = 6;
  localparam int MODE_LSB = 4;
  localparam int OCT_LSB  = 0;

  // source selection codes
  localparam logic [1:0] SRC_COLOUR = 2'h0;
  localparam logic [1:0] SRC_MAP    = 2'h2;

  // step function codes
  localparam logic [3:0] STEP_DS_RD   = 4'h2;
  localparam logic [3:0] STEP_LINE_RD = 4'h3;
  localparam logic [3:0] STEP_DS_WR   = 4'h4;
  localparam logic [3:0] STEP_LINE_WR = 4'h5;
  localparam logic [3:0] STEP_BLT     = 4'h8;
  localparam logic [3:0] STEP_INV_BLT = 4'h9;
  localparam logic [3:0] STEP_FILL    = 4'ha;

  // map selection codes
  localparam logic [3:0] MAP_A        = 4'h1;
  localparam logic [3:0] MAP_B        = 4'h2;
  localparam logic [3:0] MAP_C        = 4'h3;
  localparam logic [3:0] PAT_FG_FIXED = 4'h8;
  localparam logic [3:0] PAT_FROM_SRC = 4'h9;

  // mask modes
  localparam logic [1:0] MASK_OFF      = 2'h0;
  localparam logic [1:0] MASK_BOUNDARY = 2'h1;
  localparam logic [1:0] MASK_FULL     = 2'h2;

  // arithmetic mix codes
  localparam logic [7:0] MIX_MAX  = 8'h10;
  localparam logic [7:0] MIX_MIN  = 8'h11;
  localparam logic [7:0] MIX_ADDS = 8'h12;
  localparam logic [7:0] MIX_DMS  = 8'h13;
  localparam logic [7:0] MIX_SMD  = 8'h14;
  localparam logic [7:0] MIX_AVG  = 8'h15;

  // status bits
  localparam int ST_BUSY  = 0;
  localparam int ST_UNSUP = 1;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FETCH = 3'b001,
    ST_WAIT  = 3'b010,
    ST_WRITE = 3'b011,
    ST_NEXT  = 3'b100
  } pbt_state_t;

endpackage

// >>> verification/pbt_engine_asserts.sv
`timescale 1ns/1ps
// watches the register bus and the pixel ports of the engine
module pbt_engine_checker (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [15:0] req_dst_x,
  input wire logic [15:0] req_dst_y,
  input wire logic        rsp_valid,
  input wire logic        wr_valid,
  input wire logic        wr_ready,
  input wire logic [15:0] wr_x,
  input wire logic [7:0]  wr_data,
  input wire logic        busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // one wait state on every access
  bus_wait_a: assert property (
    (read || write) && waitrequest |=> !waitrequest)
    else $error("wait state longer than one cycle");
  start_busy_a: assert property (
    write && !waitrequest && !busy && address == pbt_pkg::PIXOP_IDX &&
    byteenable == 4'hf && writedata[27:24] == pbt_pkg::STEP_BLT
    |-> ##[1:2] busy) else $error("transfer did not start");
  // a refused step code must leave the engine idle
  bad_step_a: assert property (
    write && !waitrequest && !busy && address == pbt_pkg::PIXOP_IDX &&
    byteenable == 4'hf && writedata[27:24] == pbt_pkg::STEP_DS_RD
    |=> !busy [*3]) else $error("unsupported step started");
  idle_quiet_a: assert property (
    !busy |-> !req_valid && !wr_valid) else $error("traffic while idle");
  req_hold_a: assert property (
    req_valid && !req_ready |=> req_valid && $stable(req_dst_x) &&
    $stable(req_dst_y)) else $error("pixel request changed while held");
  one_req_a: assert property (
    req_valid && req_ready |=> !req_valid)
    else $error("second request outstanding");
  wr_hold_a: assert property (
    wr_valid && !wr_ready |=> wr_valid && $stable(wr_data) &&
    $stable(wr_x)) else $error("pixel write changed while held");
  wr_after_rsp_a: assert property (
    $rose(wr_valid) |-> $past(rsp_valid))
    else $error("write without pixel response");
  mix_narrow_a: assert property (
    read && !waitrequest && address == pbt_pkg::FG_MIX_IDX
    |-> readdata[31:8] == 24'h0) else $error("mix upper bits not zero");
endmodule

bind pbt_engine pbt_engine_checker pbt_engine_checker_i (
  .clock(clock), .sys_rst(sys_rst), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest), .req_valid(req_valid),
  .req_ready(req_ready), .req_dst_x(req_dst_x), .req_dst_y(req_dst_y),
  .rsp_valid(rsp_valid), .wr_valid(wr_valid), .wr_ready(wr_ready),
  .wr_x(wr_x), .wr_data(wr_data), .busy(busy));

// >>> verification/pbt_engine_bench.sv
`timescale 1ns/1ps
module pbt_engine_bench;
  logic        clock, sys_rst, read, write, req_ready, rsp_valid, rsp_pat;
  logic        wr_ready, req_valid, wr_valid, busy, waitrequest, e_pmap, e_inv;
  logic [7:0]  address, rsp_src, rsp_dst, wr_data;
  logic [7:0]  e_fg_mix, e_bg_mix, e_fg_col, e_bg_col;
  logic [31:0] writedata, readdata, rd;
  logic [15:0] req_dst_x, req_dst_y, req_src_x, wr_x, wr_y, e_w, e_x0, e_y0;
  logic [3:0]  req_src_map, e_smap;
  logic [1:0]  req_msk_mode, e_mmode;
  logic        rsp_msk, e_msk;
  int          n_errors, total_checks, k, i;

  pbt_engine pbt_engine_i (.clock(clock), .sys_rst(sys_rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
    .req_valid(req_valid), .req_ready(req_ready), .req_dst_x(req_dst_x),
    .req_dst_y(req_dst_y), .req_src_x(req_src_x), .req_src_y(),
    .req_pat_x(), .req_pat_y(), .req_msk_x(), .req_msk_y(),
    .req_src_map(req_src_map), .req_dst_map(), .req_pat_map(),
    .req_msk_mode(req_msk_mode), .rsp_valid(rsp_valid), .rsp_src(rsp_src),
    .rsp_dst(rsp_dst), .rsp_pat(rsp_pat), .rsp_msk(rsp_msk),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_x(wr_x), .wr_y(wr_y),
    .wr_data(wr_data), .busy(busy));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task give_verdict;
    if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // reference mix; index {~s,~d} picks the truth-table bit of codes 0-f
  function automatic logic [7:0] mix(input logic [7:0] c, s, d);
    logic [8:0] t;
    logic [7:0] r;
    t = {1'b0, s} + {1'b0, d};
    r = 8'h00;
    case (c)
      8'h10: r = s > d ? s : d;
      8'h11: r = s < d ? s : d;
      8'h12: r = t[8] ? 8'hff : t[7:0];
      8'h13: r = d > s ? d - s : 8'h00;
      8'h14: r = s > d ? s - d : 8'h00;
      8'h15: r = t[8:1];
      default: if (c < 8'h10) for (int b = 0; b < 8; b++) r[b] = c[{~s[b], ~d[b]}];
    endcase
    return r;
  endfunction

  // one avalon access; request held until waitrequest is seen low
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n == 50) n_errors++;
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  // expected pixel k: x runs fastest, source sits 10h to the right
  task check_pix;
    logic [15:0] ex, ey;
    logic [7:0]  s;
    logic        fg;
    ex = e_x0 + 16'(k % (int'(e_w) + 1));
    ey = e_y0 + 16'(k / (int'(e_w) + 1));
    fg = e_pmap ? ex[0] ^ e_inv : 1'b1;
    s = (e_smap != 4'h0) ? ex[7:0] + 8'h10 : (fg ? e_fg_col : e_bg_col);
    chk(wr_x, ex);
    chk(wr_y, ey);
    chk(wr_data, mix(fg ? e_fg_mix : e_bg_mix, s, ey[7:0] ^ 8'ha5));
    k++;
  endtask

  // far side: both readies toggle in step, so requests get held but every write finds wr_ready high
  always @(posedge clock) begin
    req_ready <= !req_ready;
    wr_ready <= !wr_ready;
    rsp_valid <= req_valid && req_ready;
    rsp_src <= req_src_x[7:0];
    rsp_dst <= req_dst_y[7:0] ^ 8'ha5;
    rsp_pat <= req_dst_x[0];
    rsp_msk <= e_msk;
    if (req_valid && req_ready) chk(req_src_map, e_smap);
    if (req_valid && req_ready) chk(req_msk_mode, e_mmode);
    if (wr_valid && wr_ready) check_pix;
  end

  // loads mixes, colours, size, destination and source, starts, and tries a mix write while busy
  task run_op(input logic [31:0] op, input logic [15:0] w, h, x, y);
    int n, ne;
    n = 0;
    ne = (int'(w) + 1) * (int'(h) + 1);
    e_w = w;
    e_x0 = x;
    e_y0 = y;
    k = 0;
    e_mmode = op[pbt_pkg::MASK_LSB +: 2];
    bus(1'b1, pbt_pkg::FG_MIX_IDX, 32'(e_fg_mix));
    bus(1'b1, pbt_pkg::BG_MIX_IDX, 32'(e_bg_mix));
    bus(1'b1, pbt_pkg::FG_COL_IDX, 32'(e_fg_col));
    bus(1'b1, pbt_pkg::BG_COL_IDX, 32'(e_bg_col));
    bus(1'b1, pbt_pkg::WIDTH_IDX, 32'(w));
    bus(1'b1, pbt_pkg::HEIGHT_IDX, 32'(h));
    bus(1'b1, pbt_pkg::DST_X_IDX, 32'(x));
    bus(1'b1, pbt_pkg::DST_Y_IDX, 32'(y));
    bus(1'b1, pbt_pkg::SRC_X_IDX, 32'(x + 16'h10));
    bus(1'b1, pbt_pkg::SRC_Y_IDX, 32'(y));
    bus(1'b1, pbt_pkg::PIXOP_IDX, op);
    bus(1'b1, pbt_pkg::FG_MIX_IDX, 32'h0000_000c);
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge clock);
      n++;
    end
    // with masking on, a pixel outside the mask is never written
    if (e_mmode != pbt_pkg::MASK_OFF && !e_msk) ne = 0;
    chk(k, ne);
    bus(1'b0, pbt_pkg::FG_MIX_IDX, 32'h0);
    chk(rd, 32'(e_fg_mix));
  endtask

  task t_regs;
    bus(1'b0, pbt_pkg::FG_MIX_IDX, 32'h0);
    chk(rd, 32'h0000_0003);
    bus(1'b0, pbt_pkg::FG_COL_IDX, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 8'h01, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, pbt_pkg::WIDTH_IDX, 32'hffff_ffff);
    bus(1'b0, pbt_pkg::WIDTH_IDX, 32'h0);
    chk(rd, 32'h0000_ffff);
  endtask

  // unsupported step flags status and writes nothing
  task t_bad_step;
    bus(1'b1, pbt_pkg::PIXOP_IDX, 32'h0211_8000);
    bus(1'b0, pbt_pkg::STATUS_IDX, 32'h0);
    chk(rd[1:0], 2'b10);
    chk(k, 0);
    bus(1'b0, pbt_pkg::PIXOP_IDX, 32'h0);
    chk(rd, 32'h0211_8000);
  endtask

  task t_fill;
    e_fg_col = 8'h05;
    e_bg_col = 8'h77;
    e_fg_mix = 8'h03;
    e_bg_mix = 8'h0c;
    run_op(32'h0811_8000, 16'h3, 16'h2, 16'd200, 16'd150);
    bus(1'b0, pbt_pkg::STATUS_IDX, 32'h0);
    chk(rd[1:0], 2'b00);
  endtask

  // boundary and full mask drop every pixel; mask off writes them all
  task t_mask;
    e_msk = 1'b0;
    run_op(32'h0811_8040, 16'h2, 16'h1, 16'h30, 16'h9);
    run_op(32'h0811_8080, 16'h2, 16'h1, 16'h30, 16'h9);
    run_op(32'h0811_8000, 16'h2, 16'h1, 16'h30, 16'h9);
    e_msk = 1'b1;
  endtask

  task t_mixes;
    e_fg_col = 8'hc3;
    for (i = 0; i < 23; i++) begin
      e_fg_mix = 8'(i);
      run_op(32'h0811_8000, 16'h1, 16'h0, 16'h20, 16'(i * 7));
    end
  endtask

  // map to map: colour registers must not leak into the result
  task t_copy;
    e_smap = pbt_pkg::MAP_A;
    e_pmap = 1'b1;
    e_fg_mix = 8'h03;
    e_bg_mix = 8'h06;
    run_op(32'ha812_3000, 16'h2, 16'h1, 16'h8, 16'h4);
    e_inv = 1'b1;
    run_op(32'ha912_3000, 16'h2, 16'h1, 16'h8, 16'h4);
  endtask

  initial begin
    sys_rst = 1'b1;
    {read, write, req_ready, wr_ready, rsp_valid, rsp_pat} = 6'h0;
    {address, rsp_src, rsp_dst, writedata} = 56'h0;
    {n_errors, total_checks, k} = 96'h0;
    {e_fg_mix, e_bg_mix, e_fg_col, e_bg_col} = 32'h0;
    {e_smap, e_pmap, e_inv} = 6'h0;
    {e_msk, rsp_msk} = 2'b11;
    e_mmode = 2'h0;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    t_regs;
    t_bad_step;
    t_fill;
    t_mask;
    t_mixes;
    t_copy;
    give_verdict;
  end

  // hang guard well beyond the few thousand cycles the run needs
  initial begin
    repeat (40000) @(posedge clock);
    n_errors++;
    give_verdict;
  end
endmodule
